// ===== design/elac_defines.vh
// register map, field positions and reset values of the loopback and alarm control block
`ifndef ELAC_DEFINES_VH
`define ELAC_DEFINES_VH

// register offsets within the control page
`define ELAC_OFS_CODING_LOOPBACK   8'h15
`define ELAC_OFS_TX_ALARM          8'h16
`define ELAC_OFS_IRQ_MASK          8'h17
`define ELAC_OFS_IRQ_CTRL          8'h1A

// reset values
`define ELAC_RST_CODING_LOOPBACK   8'h00
`define ELAC_RST_TX_ALARM          8'h00
`define ELAC_RST_IRQ_MASK          8'h00
`define ELAC_RST_IRQ_CTRL          8'h00

// coding and loopback control fields
`define ELAC_BIT_METALLIC_LOOP     6
`define ELAC_BIT_AMI_CODING        5
`define ELAC_BIT_MF_RESYNC         4
`define ELAC_BIT_DIGITAL_LOOP      3
`define ELAC_BIT_REMOTE_LOOP       2
`define ELAC_BIT_BACKPLANE_LOOP    1
`define ELAC_BIT_PAYLOAD_LOOP      0

// transmit alarm control fields
`define ELAC_BIT_SEND_ALL_ONES     7
`define ELAC_BIT_ALL_ONES_TS0      6
`define ELAC_BIT_ALL_ONES_TS16     5
`define ELAC_BIT_EBIT_VALUE        4
`define ELAC_BIT_BF_RESYNC         3
`define ELAC_BIT_CLK_RATE_SEL      2
`define ELAC_BIT_DATA_TRISTATE     1
`define ELAC_BIT_SIG_TRISTATE      0

// interrupt mask fields
`define ELAC_BIT_PRBS_WRAP_IRQ     6
`define ELAC_BIT_PRBS_ERR_IRQ      5
`define ELAC_BIT_NIBBLE_CHG_IRQ    4
`define ELAC_BIT_SABIT_CHG_IRQ     3
`define ELAC_BIT_EIGHT_SAME_IRQ    2
`define ELAC_BIT_SA6_CHG_IRQ       1
`define ELAC_BIT_SA5_CHG_IRQ       0

// interrupt control fields
`define ELAC_BIT_IRQ_ACK_TOGGLE    5
`define ELAC_IRQ_VECTOR            8'h02
`define ELAC_IRQ_VECTOR_NONE       8'h00

// time slots and Sa nibble slots
`define ELAC_SLOT_ZERO             5'h00
`define ELAC_SLOT_SIXTEEN          5'h10
`define ELAC_SA6_NIBBLE_IDX        2'h1
`define ELAC_SAME_NIBBLE_COUNT     3'h7

// recovered clock divider taps: 2048/32 = 64 kHz, 2048/256 = 8 kHz
`define ELAC_DIV_TAP_64K           4
`define ELAC_DIV_TAP_8K            7

`endif

// ===== design/elac_loopback_alarm_ctrl.v
// coding, loopback, alarm insertion and Sa/PRBS interrupt control of an E1 transceiver
`timescale 1ns/100ps
`include "elac_defines.vh"
`default_nettype none

module elac_loopback_alarm_ctrl #(
   parameter PRBS_CNT_W = 8
) (
   // clock and reset
   input  wire        clk_sys,
   input  wire        rst_b,
   // microprocessor register port
   input  wire        cpuSel,
   input  wire        cpuWr,
   input  wire        cpuRd,
   input  wire [7:0]  cpuAddr,
   input  wire [7:0]  cpuWrData,
   output reg  [7:0]  cpuRdData,
   // line pins
   input  wire        line_rx_pos,
   input  wire        line_rx_neg,
   output reg         line_tx_pos,
   output reg         line_tx_neg,
   // receiver analog input and receive LIU digital output
   output reg         rxAnaPos,
   output reg         rxAnaNeg,
   input  wire        rxLiuData,
   output reg         rxFramerData,
   // transmit framer side
   input  wire        txBitValid,
   input  wire [4:0]  txSlot,
   input  wire        txFramerData,
   input  wire        txEbitPos,
   input  wire        rxCrcCompare,
   // backplane pins
   input  wire        backplane_data_in,
   input  wire        rxBackplaneData,
   input  wire        rxBackplaneSig,
   output reg         backplane_data_out,
   output reg         backplaneDataOutEn,
   output reg         backplane_signalling_out,
   output reg         backplaneSigOutEn,
   // alarm status from the receive framer
   input  wire        lossOfSignal,
   input  wire        frameSyncLost,
   input  wire        crc_sync_lost,
   input  wire        aisRx,
   input  wire        multiframe_sync_lost,
   input  wire        slot_sixteen_alarm_rx,
   // resync triggers to the framer
   output reg         multiframe_resync_trigger,
   output reg         basic_frame_resync_trigger,
   // recovered clock
   input  wire        rxExtractClk,
   output reg         recovered_clock_out,
   // PRBS and Sa events
   input  wire        prbsErrorPulse,
   input  wire        saNibbleValid,
   input  wire [1:0]  saNibbleIdx,
   input  wire [3:0]  saNibble,
   input  wire        saBitsValid,
   input  wire [3:0]  saBits,
   // interrupt
   output reg         irqReq_b,
   output reg  [7:0]  irqVector
);

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   reg [7:0]            codingLoop_reg;
   reg [7:0]            txAlarm_reg;
   reg [7:0]            irqMask_reg;
   reg [7:0]            irqCtrl_reg;
   reg [7:0]            irqCtrlPrev_reg;
   reg                  mfTrigPrev_reg;
   reg                  bfTrigPrev_reg;

   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = cpuSel && (a == ofs);
      end
   endfunction

   wire metallic_loop_en  = codingLoop_reg[`ELAC_BIT_METALLIC_LOOP];
   wire amiCoding         = codingLoop_reg[`ELAC_BIT_AMI_CODING];
   wire digital_loop_en   = codingLoop_reg[`ELAC_BIT_DIGITAL_LOOP];
   wire remote_loop_en    = codingLoop_reg[`ELAC_BIT_REMOTE_LOOP];
   wire backplane_loop_en = codingLoop_reg[`ELAC_BIT_BACKPLANE_LOOP];
   wire payload_loop_en   = codingLoop_reg[`ELAC_BIT_PAYLOAD_LOOP];

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         codingLoop_reg  <= `ELAC_RST_CODING_LOOPBACK;
         txAlarm_reg     <= `ELAC_RST_TX_ALARM;
         irqMask_reg     <= `ELAC_RST_IRQ_MASK;
         irqCtrl_reg     <= `ELAC_RST_IRQ_CTRL;
         cpuRdData       <= 8'h00;
      end else begin
         if (cpuWr && hit(cpuAddr, `ELAC_OFS_CODING_LOOPBACK))
            codingLoop_reg <= cpuWrData & 8'h7F;
         if (cpuWr && hit(cpuAddr, `ELAC_OFS_TX_ALARM))
            txAlarm_reg <= cpuWrData;
         if (cpuWr && hit(cpuAddr, `ELAC_OFS_IRQ_MASK))
            irqMask_reg <= cpuWrData & 8'h7F;
         if (cpuWr && hit(cpuAddr, `ELAC_OFS_IRQ_CTRL))
            irqCtrl_reg <= cpuWrData & 8'h20;
         if (cpuRd && hit(cpuAddr, `ELAC_OFS_CODING_LOOPBACK))
            cpuRdData <= codingLoop_reg;
         else if (cpuRd && hit(cpuAddr, `ELAC_OFS_TX_ALARM))
            cpuRdData <= txAlarm_reg;
         else if (cpuRd && hit(cpuAddr, `ELAC_OFS_IRQ_MASK))
            cpuRdData <= irqMask_reg;
         else if (cpuRd && hit(cpuAddr, `ELAC_OFS_IRQ_CTRL))
            cpuRdData <= irqCtrl_reg;
         else if (cpuRd)
            cpuRdData <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three flops, accepted when stages two and three agree
   localparam NSYNC = 4;
   wire [NSYNC-1:0] pinRaw = {rxExtractClk, backplane_data_in, line_rx_neg, line_rx_pos};
   reg  [NSYNC-1:0] syncA_reg;
   reg  [NSYNC-1:0] syncB_reg;
   reg  [NSYNC-1:0] syncC_reg;
   reg  [NSYNC-1:0] pinF_reg;
   genvar g;
   generate
      for (g = 0; g < NSYNC; g = g + 1) begin : gSync
         always @(posedge clk_sys) begin
            if (!rst_b) begin
               syncA_reg[g] <= 1'b0;
               syncB_reg[g] <= 1'b0;
               syncC_reg[g] <= 1'b0;
               pinF_reg[g]  <= 1'b0;
            end else begin
               syncA_reg[g] <= pinRaw[g];
               syncB_reg[g] <= syncA_reg[g];
               syncC_reg[g] <= syncB_reg[g];
               if (syncB_reg[g] == syncC_reg[g])
                  pinF_reg[g] <= syncC_reg[g];
            end
         end
      end
   endgenerate
   wire rxPos = pinF_reg[0];
   wire rxNeg = pinF_reg[1];
   wire bpIn  = pinF_reg[2];
   wire exClk = pinF_reg[3];

   ////////////////////////////////////////////////////////////////////////////////
   // transmit bit selection and HDB3/AMI encoder
   reg        txBit;
   reg [3:0]  hdbDly_reg;
   reg [3:0]  hdbViol_reg;
   reg [1:0]  zeroRun_reg;
   reg        lastPol_reg;
   reg        violPol_reg;
   reg        oddMarks_reg;
   reg        encPos_reg;
   reg        encNeg_reg;

   always @* begin
      txBit = txFramerData;
      if (payload_loop_en && txSlot != `ELAC_SLOT_ZERO)
         txBit = rxLiuData;
      if (txEbitPos)
         txBit = crc_sync_lost ? txAlarm_reg[`ELAC_BIT_EBIT_VALUE]
                               : rxCrcCompare;
      if (txAlarm_reg[`ELAC_BIT_ALL_ONES_TS0] && txSlot == `ELAC_SLOT_ZERO)
         txBit = 1'b1;
      if (txAlarm_reg[`ELAC_BIT_ALL_ONES_TS16] && txSlot == `ELAC_SLOT_SIXTEEN)
         txBit = 1'b1;
      if (txAlarm_reg[`ELAC_BIT_SEND_ALL_ONES])
         txBit = 1'b1;
   end

   // four bits of delay let a fourth zero rewrite the group as B00V or 000V
   wire fourZeros = !txBit && zeroRun_reg == 2'h3 && !amiCoding;
   wire outMark   = hdbDly_reg[3];
   wire outViol   = hdbViol_reg[3];

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         hdbDly_reg   <= 4'h0;
         hdbViol_reg  <= 4'h0;
         zeroRun_reg  <= 2'h0;
         lastPol_reg  <= 1'b0;
         violPol_reg  <= 1'b0;
         oddMarks_reg <= 1'b0;
         encPos_reg   <= 1'b0;
         encNeg_reg   <= 1'b0;
      end else if (txBitValid) begin
         if (fourZeros) begin
            hdbDly_reg  <= {oddMarks_reg ? 1'b0 : 1'b1, 3'h1};
            hdbViol_reg <= 4'h1;
            zeroRun_reg <= 2'h0;
            oddMarks_reg <= 1'b0;
         end else begin
            hdbDly_reg  <= {hdbDly_reg[2:0], txBit};
            hdbViol_reg <= {hdbViol_reg[2:0], 1'b0};
            zeroRun_reg <= txBit ? 2'h0 : zeroRun_reg + 2'h1;
            oddMarks_reg <= oddMarks_reg ^ txBit;
         end
         if (outMark && outViol) begin
            encPos_reg  <= lastPol_reg;
            encNeg_reg  <= !lastPol_reg;
            violPol_reg <= lastPol_reg;
         end else if (outMark) begin
            encPos_reg  <= !lastPol_reg;
            encNeg_reg  <= lastPol_reg;
            lastPol_reg <= !lastPol_reg;
         end else begin
            encPos_reg  <= 1'b0;
            encNeg_reg  <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // loopback routing and backplane drivers
   wire dataHide = txAlarm_reg[`ELAC_BIT_DATA_TRISTATE] &&
                   (lossOfSignal || frameSyncLost || crc_sync_lost || aisRx);
   wire sigHide  = txAlarm_reg[`ELAC_BIT_SIG_TRISTATE] &&
                   (multiframe_sync_lost || slot_sixteen_alarm_rx);

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         line_tx_pos              <= 1'b0;
         line_tx_neg              <= 1'b0;
         rxAnaPos                 <= 1'b0;
         rxAnaNeg                 <= 1'b0;
         rxFramerData             <= 1'b0;
         backplane_data_out       <= 1'b0;
         backplaneDataOutEn       <= 1'b0;
         backplane_signalling_out <= 1'b0;
         backplaneSigOutEn        <= 1'b0;
      end else begin
         line_tx_pos <= remote_loop_en ? rxPos : encPos_reg;
         line_tx_neg <= remote_loop_en ? rxNeg : encNeg_reg;
         rxAnaPos    <= metallic_loop_en ? line_tx_pos : rxPos;
         rxAnaNeg    <= metallic_loop_en ? line_tx_neg : rxNeg;
         rxFramerData <= digital_loop_en ? txBit : rxLiuData;
         backplane_data_out <= backplane_loop_en ? bpIn : rxBackplaneData;
         backplaneDataOutEn <= !dataHide;
         backplane_signalling_out <= rxBackplaneSig;
         backplaneSigOutEn  <= !sigHide;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // resync triggers on falling edge of the software bits
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         mfTrigPrev_reg             <= 1'b0;
         bfTrigPrev_reg             <= 1'b0;
         multiframe_resync_trigger  <= 1'b0;
         basic_frame_resync_trigger <= 1'b0;
      end else begin
         mfTrigPrev_reg <= codingLoop_reg[`ELAC_BIT_MF_RESYNC];
         bfTrigPrev_reg <= txAlarm_reg[`ELAC_BIT_BF_RESYNC];
         multiframe_resync_trigger  <= mfTrigPrev_reg &&
                                       !codingLoop_reg[`ELAC_BIT_MF_RESYNC];
         basic_frame_resync_trigger <= bfTrigPrev_reg &&
                                       !txAlarm_reg[`ELAC_BIT_BF_RESYNC];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // recovered clock divider
   reg [7:0] clkDiv_reg;
   reg       exClkPrev_reg;
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         clkDiv_reg          <= 8'h00;
         exClkPrev_reg       <= 1'b0;
         recovered_clock_out <= 1'b0;
      end else begin
         exClkPrev_reg <= exClk;
         if (exClk && !exClkPrev_reg)
            clkDiv_reg <= clkDiv_reg + 8'h01;
         recovered_clock_out <= txAlarm_reg[`ELAC_BIT_CLK_RATE_SEL] ?
                                clkDiv_reg[`ELAC_DIV_TAP_64K] :
                                clkDiv_reg[`ELAC_DIV_TAP_8K];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // PRBS and Sa event detection, interrupt request
   reg [PRBS_CNT_W-1:0] prbsCnt_reg;
   reg [3:0]            saNib_reg [0:3];
   reg [3:0]            saBitsPrev_reg;
   reg [2:0]            sameCnt_reg;
   reg                  saBitsSeen_reg;
   reg [3:0]            nibSeen_reg;
   integer              i;

   wire prbsWrap  = prbsErrorPulse && (&prbsCnt_reg);
   wire nibChg    = saNibbleValid && nibSeen_reg[saNibbleIdx] &&
                    saNib_reg[saNibbleIdx] != saNibble;
   wire isSa6     = saNibbleValid && saNibbleIdx == `ELAC_SA6_NIBBLE_IDX;
   wire sa6Chg    = isSa6 && nibChg;
   wire sa6Same   = isSa6 && nibSeen_reg[saNibbleIdx] && !nibChg;
   wire eightSame = sa6Same && sameCnt_reg == `ELAC_SAME_NIBBLE_COUNT - 3'h1;
   wire bitChg    = saBitsValid && saBitsSeen_reg && saBits != saBitsPrev_reg;
   wire sa5Chg    = saBitsValid && saBitsSeen_reg && saBits[0] != saBitsPrev_reg[0];
   wire ackToggle = irqCtrl_reg[`ELAC_BIT_IRQ_ACK_TOGGLE] !=
                    irqCtrlPrev_reg[`ELAC_BIT_IRQ_ACK_TOGGLE];
   wire irqEvent  =
      (irqMask_reg[`ELAC_BIT_PRBS_WRAP_IRQ]   && prbsWrap)       ||
      (irqMask_reg[`ELAC_BIT_PRBS_ERR_IRQ]    && prbsErrorPulse) ||
      (irqMask_reg[`ELAC_BIT_NIBBLE_CHG_IRQ]  && nibChg)         ||
      (irqMask_reg[`ELAC_BIT_SABIT_CHG_IRQ]   && bitChg)         ||
      (irqMask_reg[`ELAC_BIT_EIGHT_SAME_IRQ]  && eightSame)      ||
      (irqMask_reg[`ELAC_BIT_SA6_CHG_IRQ]     && sa6Chg)         ||
      (irqMask_reg[`ELAC_BIT_SA5_CHG_IRQ]     && sa5Chg);

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         prbsCnt_reg     <= {PRBS_CNT_W{1'b0}};
         saBitsPrev_reg  <= 4'h0;
         saBitsSeen_reg  <= 1'b0;
         nibSeen_reg     <= 4'h0;
         sameCnt_reg     <= 3'h0;
         irqCtrlPrev_reg <= `ELAC_RST_IRQ_CTRL;
         irqReq_b        <= 1'b1;
         irqVector       <= `ELAC_IRQ_VECTOR_NONE;
         for (i = 0; i < 4; i = i + 1)
            saNib_reg[i] <= 4'h0;
      end else begin
         if (prbsErrorPulse)
            prbsCnt_reg <= prbsCnt_reg + {{(PRBS_CNT_W-1){1'b0}}, 1'b1};
         if (saBitsValid) begin
            saBitsPrev_reg <= saBits;
            saBitsSeen_reg <= 1'b1;
         end
         if (saNibbleValid) begin
            saNib_reg[saNibbleIdx]   <= saNibble;
            nibSeen_reg[saNibbleIdx] <= 1'b1;
         end
         if (isSa6)
            sameCnt_reg <= sa6Same ? (eightSame ? 3'h0 : sameCnt_reg + 3'h1) : 3'h0;
         irqCtrlPrev_reg <= irqCtrl_reg;
         // new event beats a simultaneous acknowledge
         if (irqEvent) begin
            irqReq_b  <= 1'b0;
            irqVector <= `ELAC_IRQ_VECTOR;
         end else if (ackToggle) begin
            irqReq_b  <= 1'b1;
            irqVector <= `ELAC_IRQ_VECTOR_NONE;
         end
      end
   end

endmodule

`default_nettype wire

// ===== tb/elac_loopback_alarm_ctrl_props.sv
// concurrent checks on the ports of the loopback and alarm control block
`timescale 1ns/100ps
`default_nettype none
module elac_props (
   // clock, reset and register port
   input wire       clk_sys, rst_b, cpuSel, cpuWr, cpuRd,
   input wire [7:0] cpuAddr, cpuWrData, cpuRdData,
   // alarm status and events
   input wire       lossOfSignal, frameSyncLost, crc_sync_lost, aisRx,
   input wire       multiframe_sync_lost, slot_sixteen_alarm_rx,
   input wire       prbsErrorPulse, saNibbleValid, saBitsValid,
   // outputs under check
   input wire       backplaneDataOutEn, backplaneSigOutEn, irqReq_b,
   input wire [7:0] irqVector,
   input wire       multiframe_resync_trigger, basic_frame_resync_trigger
);
   reg  [7:0] sh15;
   reg  [7:0] sh16;
   reg  [7:0] sh17;
   reg        shAck;
   wire       wrEn     = cpuSel && cpuWr;
   wire       rdEn     = cpuSel && cpuRd;
   wire       anyEvt   = prbsErrorPulse || saNibbleValid || saBitsValid;
   wire       dataLoss = lossOfSignal || frameSyncLost || crc_sync_lost || aisRx;
   wire       sigLoss  = multiframe_sync_lost || slot_sixteen_alarm_rx;
   wire       ackTog   = wrEn && cpuAddr == 8'h1A && cpuWrData[5] != shAck;
   wire       mfFall   = wrEn && cpuAddr == 8'h15 && sh15[4] && !cpuWrData[4];
   wire       bfFall   = wrEn && cpuAddr == 8'h16 && sh16[3] && !cpuWrData[3];

   // shadow of the control words, updated on the write edge
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         {sh15, sh16, sh17, shAck} <= 25'h0;
      end else if (wrEn) begin
         case (cpuAddr)
            8'h15: sh15 <= cpuWrData & 8'h7F;
            8'h16: sh16 <= cpuWrData;
            8'h17: sh17 <= cpuWrData & 8'h7F;
            8'h1A: shAck <= cpuWrData[5];
            default: ;
         endcase
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_data_tristate: assert property ($past(rst_b) |->
      backplaneDataOutEn == !($past(sh16[1]) && $past(dataLoss))) else $error("bad data enable");
   a_sig_tristate: assert property ($past(rst_b) |->
      backplaneSigOutEn == !($past(sh16[0]) && $past(sigLoss))) else $error("bad sig enable");
   a_irq_set: assert property (prbsErrorPulse && sh17[5] |=>
      !irqReq_b && irqVector == 8'h02) else $error("irq not raised");
   a_irq_quiet: assert property (irqReq_b && sh17 == 8'h00 && $past(sh17) == 8'h00 |=>
      irqReq_b) else $error("masked event raised irq");
   a_irq_ack: assert property (ackTog && !anyEvt ##1 !anyEvt |=>
      irqReq_b && irqVector == 8'h00) else $error("ack did not clear irq");
   a_mf_trigger: assert property (mfFall |->
      ##2 multiframe_resync_trigger ##1 !multiframe_resync_trigger) else $error("no mf pulse");
   a_mf_cause: assert property (multiframe_resync_trigger |->
      $past(mfFall, 2)) else $error("mf pulse without falling bit");
   a_bf_trigger: assert property (bfFall |->
      ##2 basic_frame_resync_trigger ##1 !basic_frame_resync_trigger) else $error("no bf pulse");
   a_read_coding: assert property (rdEn && cpuAddr == 8'h15 |=>
      cpuRdData == $past(sh15)) else $error("bad read of coding word");
   a_read_alarm: assert property (rdEn && cpuAddr == 8'h16 |=>
      cpuRdData == $past(sh16)) else $error("bad read of alarm word");
endmodule

bind elac_loopback_alarm_ctrl elac_props u_props (
   .clk_sys(clk_sys), .rst_b(rst_b), .cpuSel(cpuSel), .cpuWr(cpuWr), .cpuRd(cpuRd),
   .cpuAddr(cpuAddr), .cpuWrData(cpuWrData), .cpuRdData(cpuRdData),
   .lossOfSignal(lossOfSignal), .frameSyncLost(frameSyncLost), .crc_sync_lost(crc_sync_lost),
   .aisRx(aisRx), .multiframe_sync_lost(multiframe_sync_lost),
   .slot_sixteen_alarm_rx(slot_sixteen_alarm_rx), .prbsErrorPulse(prbsErrorPulse),
   .saNibbleValid(saNibbleValid), .saBitsValid(saBitsValid),
   .backplaneDataOutEn(backplaneDataOutEn), .backplaneSigOutEn(backplaneSigOutEn),
   .irqReq_b(irqReq_b), .irqVector(irqVector),
   .multiframe_resync_trigger(multiframe_resync_trigger),
   .basic_frame_resync_trigger(basic_frame_resync_trigger)
);
`default_nettype wire

// ===== tb/elac_line_partner.sv
// remote line equipment: repeating bipolar pattern on the receive pair
`timescale 1ns/100ps
`default_nettype none
module elac_line_partner #(
   parameter int BIT_CYC = 12
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // bipolar receive pair of the device
   output var  logic line_rx_pos,
   output var  logic line_rx_neg
);
   logic [7:0] patReg;
   logic [7:0] cycReg;
   logic       polReg;

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         {patReg, cycReg, polReg, line_rx_pos, line_rx_neg} <= {8'hB4, 8'h00, 3'b000};
      end else if (cycReg == 8'(BIT_CYC - 1)) begin
         cycReg <= 8'h00;
         patReg <= {patReg[6:0], patReg[7]};
         // marks alternate polarity, spaces rest both pins low
         line_rx_pos <= patReg[7] && !polReg;
         line_rx_neg <= patReg[7] && polReg;
         polReg <= polReg ^ patReg[7];
      end else begin
         cycReg <= cycReg + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the loopback and alarm control block
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        clk_sys, rst_b, cpuSel, cpuWr, cpuRd, bpIn, prbsErr, nibVld, bitsVld;
   logic        ackVal, txPrev;
   logic [7:0]  cpuAddr, cpuWrData;
   logic [5:0]  cond;
   logic [1:0]  nibIdx;
   logic [3:0]  nib, bits;
   logic [15:0] tick = 16'h0;
   int          errorCnt, nCompared, mfCnt, bfCnt, prbsTot, posRises, wdog;
   wire         rxPos, rxNeg, txPos, txNeg, dOut, dEn, sEn, mfTrig, bfTrig, recClk, irqReq_b;
   wire         fData, sOut;
   wire  [7:0]  rdData, irqVec;

   elac_loopback_alarm_ctrl uut (
      .clk_sys(clk_sys), .rst_b(rst_b), .cpuSel(cpuSel), .cpuWr(cpuWr), .cpuRd(cpuRd),
      .cpuAddr(cpuAddr), .cpuWrData(cpuWrData), .cpuRdData(rdData),
      .line_rx_pos(rxPos), .line_rx_neg(rxNeg), .line_tx_pos(txPos), .line_tx_neg(txNeg),
      .rxAnaPos(), .rxAnaNeg(), .rxLiuData(tick[4]), .rxFramerData(fData),
      .txBitValid(tick[2:0] == 3'h7), .txSlot(tick[10:6]), .txFramerData(tick[3]),
      .txEbitPos(1'b0), .rxCrcCompare(1'b0), .backplane_data_in(bpIn),
      .rxBackplaneData(!bpIn), .rxBackplaneSig(bpIn), .backplane_data_out(dOut),
      .backplaneDataOutEn(dEn), .backplane_signalling_out(sOut), .backplaneSigOutEn(sEn),
      .lossOfSignal(cond[0]), .frameSyncLost(cond[1]), .crc_sync_lost(cond[2]),
      .aisRx(cond[3]), .multiframe_sync_lost(cond[4]), .slot_sixteen_alarm_rx(cond[5]),
      .multiframe_resync_trigger(mfTrig), .basic_frame_resync_trigger(bfTrig),
      .rxExtractClk(tick[1]), .recovered_clock_out(recClk), .prbsErrorPulse(prbsErr),
      .saNibbleValid(nibVld), .saNibbleIdx(nibIdx), .saNibble(nib), .saBitsValid(bitsVld),
      .saBits(bits), .irqReq_b(irqReq_b), .irqVector(irqVec)
   );
   elac_line_partner #(.BIT_CYC(12)) partner (
      .clk_sys(clk_sys), .rst_b(rst_b), .line_rx_pos(rxPos), .line_rx_neg(rxNeg)
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(negedge clk_sys) tick <= tick + 16'h1;
   always @(posedge clk_sys) begin
      mfCnt += int'(mfTrig === 1'b1);
      bfCnt += int'(bfTrig === 1'b1);
      posRises += int'(txPos === 1'b1 && !txPrev);
      txPrev = (txPos === 1'b1);
      wdog++;
      if (wdog == 60000) begin
         errorCnt++;
         printVerdict;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errorCnt++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic waitN(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      {cpuSel, cpuWr, cpuAddr, cpuWrData} = {2'b11, a, d};
      @(negedge clk_sys);
      {cpuSel, cpuWr} = 2'b00;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      {cpuSel, cpuRd, cpuAddr} = {2'b11, a};
      @(negedge clk_sys);
      {cpuSel, cpuRd} = 2'b00;
      chk("register", rdData, exp);
   endtask
   task automatic pulseErr;
      @(negedge clk_sys);
      prbsErr = 1'b1;
      prbsTot++;
      @(negedge clk_sys);
      prbsErr = 1'b0;
      waitN(1);
   endtask
   task automatic ack;
      ackVal = !ackVal;
      wr(8'h1A, {2'b00, ackVal, 5'h00});
      waitN(2);
      chk("irq after ack", {irqReq_b, irqVec}, 9'h100);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      logic [7:0] ofs [4] = '{8'h15, 8'h16, 8'h17, 8'h1A};
      logic [7:0] used [4] = '{8'h7F, 8'hFF, 8'h7F, 8'h20};
      for (int i = 0; i < 4; i++) begin
         rd(ofs[i], 8'h00);
         wr(ofs[i], 8'hFF);
         rd(ofs[i], used[i]);
         wr(ofs[i], 8'h00);
      end
      wr(8'h30, 8'hFF);
      rd(8'h30, 8'h00);
   endtask
   task automatic t_tristate;
      wr(8'h16, 8'h03);
      for (int i = 0; i < 6; i++) begin
         cond = 6'h01 << i;
         waitN(2);
         chk("data enable", dEn, i > 3);
         chk("sig enable", sEn, i < 4);
      end
      wr(8'h16, 8'h00);
      waitN(2);
      chk("enables", {dEn, sEn}, 2'b11);
      cond = 6'h00;
   endtask
   task automatic t_bp_loop;
      wr(8'h15, 8'h02);
      for (int v = 0; v < 2; v++) begin
         bpIn = v[0];
         waitN(8);
         chk("backplane loop", dOut, v[0]);
         chk("signalling out", sOut, v[0]);
      end
      wr(8'h15, 8'h00);
      waitN(8);
      chk("backplane normal", dOut, 1'b0);
   endtask
   task automatic t_prbs;
      pulseErr;
      chk("masked error", irqReq_b, 1'b1);
      wr(8'h17, 8'h20);
      pulseErr;
      chk("irq on error", {irqReq_b, irqVec}, 9'h002);
      ack;
      wr(8'h17, 8'h40);
      while (prbsTot < 256) begin
         pulseErr;
         chk("irq on wrap", irqReq_b, prbsTot != 256);
      end
      ack;
   endtask
   task automatic sa_evt(input logic [15:0] r);
      wr(8'h17, r[15:8]);
      @(negedge clk_sys);
      {nibVld, bitsVld, nibIdx, nib, bits} = {r[7], !r[7], r[6:5], r[4:1], r[4:1]};
      @(negedge clk_sys);
      {nibVld, bitsVld} = 2'b00;
      waitN(1);
      chk("sa irq", irqReq_b, !r[0]);
      if (r[0])
         ack;
   endtask
   task automatic t_sa;
      logic [15:0] tab [12] = '{16'h0100, 16'h0104, 16'h0107, 16'h0806, 16'h0817,
         16'h02AA, 16'h0286, 16'h02AA, 16'h02AD, 16'h10C2, 16'h10C2, 16'h10D3};
      foreach (tab[i])
         sa_evt(tab[i]);
      for (int k = 0; k < 7; k++)
         sa_evt({8'h04, 1'b1, 2'h1, 4'h6, k == 6});
   endtask
   task automatic t_resync;
      int m0;
      m0 = mfCnt;
      wr(8'h15, 8'h10);
      waitN(12500);
      chk("mf trigger held", mfCnt - m0, 0);
      wr(8'h15, 8'h00);
      wr(8'h16, 8'h08);
      waitN(12500);
      wr(8'h16, 8'h00);
      waitN(4);
      chk("mf trigger", mfCnt - m0, 1);
      chk("bf trigger", bfCnt, 2);
   endtask
   task automatic t_clk(input logic [7:0] v, input logic [31:0] exp);
      time t0;
      wr(8'h16, v);
      repeat (2) @(posedge recClk);
      t0 = $time;
      @(posedge recClk);
      chk("clock period", 32'(($time - t0) / 10), exp);
   endtask
   task automatic t_line;
      int p0;
      wr(8'h15, 8'h04);
      @(posedge rxPos);
      waitN(6);
      chk("remote loop pos", {txPos, txNeg}, 2'b10);
      @(posedge rxNeg);
      waitN(6);
      chk("remote loop neg", {txPos, txNeg}, 2'b01);
      wr(8'h15, 8'h08);
      wr(8'h16, 8'h80);
      waitN(48);
      chk("digital loop", fData, 1'b1);
      waitN(16);
      p0 = posRises;
      waitN(256);
      chk("all ones marks", posRises - p0, 16);
      chk("digital loop", fData, 1'b1);
   endtask
   task automatic printVerdict;
      $display("compared %0d errors %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      {rst_b, cpuSel, cpuWr, cpuRd, bpIn, prbsErr, nibVld, bitsVld, ackVal} = 9'h0;
      {cpuAddr, cpuWrData, cond, nibIdx, nib, bits} = 32'h0;
      waitN(6);
      rst_b = 1'b1;
      t_regs;
      t_tristate;
      t_bp_loop;
      t_prbs;
      t_sa;
      t_resync;
      t_clk(8'h04, 32'd128);
      t_clk(8'h00, 32'd1024);
      t_line;
      printVerdict;
   end
endmodule
`default_nettype wire
